/* File: inc/mhpi_pkg.sv */
// Package of constants and types for the modem host pin interface.
package mhpi_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] ADDR_FLOW_MODE  = 4'h0;
    localparam logic [3:0] ADDR_INT_CLEAR  = 4'h1;
    localparam logic [3:0] ADDR_PIN_MODE   = 4'h2;
    localparam logic [3:0] ADDR_PIN_OUT    = 4'h3;
    localparam logic [3:0] ADDR_PIN_DIR    = 4'h4;
    localparam logic [3:0] ADDR_STATUS     = 4'h5;
    localparam logic [3:0] ADDR_PIN_IN     = 4'h6;
    localparam logic [3:0] ADDR_RX_DATA    = 4'h7;

    localparam int          FLOW_MODE_BIT  = 7;
    localparam int          INT_CLEAR_HI   = 7;
    localparam int          INT_CLEAR_LO   = 6;
    localparam logic [7:0]  RST_FLOW_MODE  = 8'h00;
    localparam logic [9:0]  RST_PIN_MODE   = 10'h000;
    localparam logic [4:0]  RST_PIN_OUT    = 5'h00;
    localparam logic [4:0]  RST_PIN_DIR    = 5'h00;

    // ****************************************************************
    // Serial timing
    // ****************************************************************
    localparam int          CLK_HZ         = 20000000;
    localparam int          BAUD_DEFAULT   = 9600;
    localparam int          BIT_CYCLES     = CLK_HZ / BAUD_DEFAULT;
    localparam int          FIFO_DEPTH     = 16;

    // ****************************************************************
    // Pin function modes, two bits per multi-function pin
    // ****************************************************************
    typedef enum logic [1:0] {
        MHPI_PIN_IN  = 2'b00,
        MHPI_PIN_OUT = 2'b01,
        MHPI_PIN_ALT = 2'b10,
        MHPI_PIN_RSV = 2'b11
    } mhpi_pin_mode_t;

    typedef struct packed {
        logic carrier_loss;
        logic wake_on_ring;
        logic loop_loss;
        logic v23_reversal;
        logic intrusion;
    } mhpi_events_t;

    typedef struct packed {
        logic ring_on;
        logic carrier_present;
        logic frame_end;
        logic connected;
        logic sleeping;
    } mhpi_modem_state_t;

    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
    } mhpi_pins_t;

endpackage : mhpi_pkg

/* File: src/mhpi_uart_rx.sv */
// Serial receiver that takes host characters from the transmit data line.
`timescale 1ns/1ns
module mhpi_uart_rx #(
    parameter int BIT_CYCLES = mhpi_pkg::BIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       rxd_sync,
    output logic            start_seen,
    output logic            byte_valid,
    output logic [7:0]      byte_data
);
    import mhpi_pkg::*;

    localparam int CW = $clog2(BIT_CYCLES + 1);

    typedef enum logic [1:0] {
        MHPI_RX_IDLE  = 2'b00,
        MHPI_RX_START = 2'b01,
        MHPI_RX_DATA  = 2'b10,
        MHPI_RX_STOP  = 2'b11
    } mhpi_rx_state_t;

    mhpi_rx_state_t state, next_state;
    logic [CW-1:0]  cnt, next_cnt;
    logic [2:0]     bitn, next_bitn;
    logic [7:0]     shift, next_shift;
    logic           next_start_seen;
    logic           next_byte_valid;
    logic [7:0]     next_byte_data;

    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_bitn       = bitn;
        next_shift      = shift;
        next_byte_valid = 1'b0;
        next_byte_data  = byte_data;
        unique case (state)
            MHPI_RX_IDLE: begin
                if (!rxd_sync) begin
                    next_state      = MHPI_RX_START;
                    next_cnt        = CW'(BIT_CYCLES / 2);
                end
            end
            MHPI_RX_START: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (rxd_sync) begin
                    next_state = MHPI_RX_IDLE;
                end else begin
                    next_state = MHPI_RX_DATA;
                    next_cnt   = CW'(BIT_CYCLES - 1);
                    next_bitn  = 3'h0;
                end
            end
            MHPI_RX_DATA: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_shift = {rxd_sync, shift[7:1]};
                    next_cnt   = CW'(BIT_CYCLES - 1);
                    next_bitn  = bitn + 1'b1;
                    if (bitn == 3'h7) begin
                        next_state = MHPI_RX_STOP;
                    end
                end
            end
            MHPI_RX_STOP: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_state = MHPI_RX_IDLE;
                    if (rxd_sync) begin
                        next_byte_valid = 1'b1;
                        next_byte_data  = shift;
                    end
                end
            end
        endcase
        // High while a frame is in flight.
        next_start_seen = (next_state != MHPI_RX_IDLE);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= MHPI_RX_IDLE;
            cnt        <= '0;
            bitn       <= 3'h0;
            shift      <= 8'h00;
            start_seen <= 1'b0;
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            bitn       <= next_bitn;
            shift      <= next_shift;
            start_seen <= next_start_seen;
            byte_valid <= next_byte_valid;
            byte_data  <= next_byte_data;
        end
    end

endmodule : mhpi_uart_rx

/* File: src/mhpi_uart_tx.sv */
// Serial transmitter that sends modem data to the host on the receive data line.
`timescale 1ns/1ns
module mhpi_uart_tx #(
    parameter int BIT_CYCLES = mhpi_pkg::BIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       load,
    input  wire logic [7:0] data,
    output logic            busy,
    output logic            txd
);
    import mhpi_pkg::*;

    localparam int CW = $clog2(BIT_CYCLES + 1);

    logic [9:0]    frame, next_frame;
    logic [3:0]    left, next_left;
    logic [CW-1:0] cnt, next_cnt;
    logic          next_busy;
    logic          next_txd;

    always_comb begin
        next_frame = frame;
        next_left  = left;
        next_cnt   = cnt;
        next_busy  = busy;
        next_txd   = txd;
        if (!busy) begin
            if (load) begin
                next_frame = {1'b1, data, 1'b0};
                next_left  = 4'ha;
                next_cnt   = '0;
                next_busy  = 1'b1;
            end
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else if (left == 4'h0) begin
            next_busy = 1'b0;
            next_txd  = 1'b1;
        end else begin
            next_txd   = frame[0];
            next_frame = {1'b1, frame[9:1]};
            next_left  = left - 1'b1;
            next_cnt   = CW'(BIT_CYCLES - 1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame <= 10'h3ff;
            left  <= 4'h0;
            cnt   <= '0;
            busy  <= 1'b0;
            txd   <= 1'b1;
        end else begin
            frame <= next_frame;
            left  <= next_left;
            cnt   <= next_cnt;
            busy  <= next_busy;
            txd   <= next_txd;
        end
    end

endmodule : mhpi_uart_tx

/* File: src/mhpi_top.sv */
// Host pin logic of the modem: serial pair, clear-to-send, reset and multi-function pins.
//
// Contract
// - Mode 0: negate clear-to-send on start bit, reassert when transmit FIFO empties.
// - Mode 1: negate at 70% FIFO occupancy, reassert at 30% or less; with 16 entries the code negates at 11 and reasserts at 5 or less.
// - Mode selector is bit 7, read/write; bits 6:0 read zero.
// - Received data goes out on receive data; host data comes in on transmit data.
// - Clear-to-send asserted only when more data fits; host sends only then.
// - Reset input low returns every control register to its initial state.
// - A low pulse on reset also wakes the device from sleep.
// - Pin five resets to input; may be output or ring indicator.
// - Pin four resets to input; as interrupt flags five events while connected.
// - Interrupt stays set until host writes bits 7:6 of the clear register.
// - Pin three resets to input; as escape, rising edge leaves online mode.
// - Pin two resets to input; as carrier detect, drives low on carrier.
// - Pin one resets to input; may signal end of received HDLC frame.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module mhpi_top #(
    parameter int DEPTH      = mhpi_pkg::FIFO_DEPTH,
    parameter int BIT_CYCLES = mhpi_pkg::BIT_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        reset_n_pin,
    input  wire logic                        txd_pin,
    output logic                             rxd_pin,
    output logic                             cts_n_pin,
    input  wire logic [4:0]                  multi_pin_in,
    output logic [4:0]                       multi_pin_out,
    output logic [4:0]                       multi_pin_oe,
    input  wire mhpi_pkg::mhpi_events_t      modem_events,
    input  wire mhpi_pkg::mhpi_modem_state_t modem_state,
    input  wire logic                        tx_fifo_pop,
    output logic                             tx_fifo_valid,
    output logic [7:0]                       tx_fifo_data,
    input  wire logic                        rx_valid,
    input  wire logic [7:0]                  rx_data,
    output logic                             rx_ready,
    output logic                             escape_to_command,
    output logic                             wake_pulse,
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata
);
    import mhpi_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int OW = AW + 1;
    localparam logic [OW-1:0] HI_MARK = OW'((DEPTH * 7) / 10);
    localparam logic [OW-1:0] LO_MARK = OW'((DEPTH * 3 + 9) / 10);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [7:0] sync1, sync2;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= 8'hff;
            sync2 <= 8'hff;
        end else begin
            sync1 <= {reset_n_pin, txd_pin, 1'b1, multi_pin_in};
            sync2 <= sync1;
        end
    end

    logic       rst_n_s, txd_s;
    logic [4:0] pin_s;
    assign rst_n_s = sync2[7];
    assign txd_s   = sync2[6];
    assign pin_s   = sync2[4:0];

    // The reset pin clears the block as the system reset does, except the synchronisers, rst_prev and reg_rdata.
    logic soft_rst;
    assign soft_rst = sys_rst | ~rst_n_s;

    // ****************************************************************
    // Serial pair
    // ****************************************************************
    logic       start_seen, rx_byte_valid, tx_busy;
    logic [7:0] rx_byte;

    mhpi_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clk        (clk),
        .sys_rst    (soft_rst),
        .rxd_sync   (txd_s),
        .start_seen (start_seen),
        .byte_valid (rx_byte_valid),
        .byte_data  (rx_byte)
    );

    logic tx_load;
    assign tx_load  = rx_valid & ~tx_busy;
    assign rx_ready = ~tx_busy;

    mhpi_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .clk  (clk),
        .sys_rst (soft_rst),
        .load (tx_load),
        .data (rx_data),
        .busy (tx_busy),
        .txd  (rxd_pin)
    );

    // ****************************************************************
    // Transmit FIFO of host characters
    // ****************************************************************
    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [OW-1:0] level, next_level;
    logic          push, pop;

    // A character into a full FIFO is dropped; flow control prevents that.
    assign push = rx_byte_valid & (level != OW'(DEPTH));
    assign pop  = tx_fifo_pop & (level != '0);

    always_comb begin
        next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
        next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
        next_level = level + OW'(push) - OW'(pop);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= rx_byte;
        end
        if (soft_rst) begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            level <= next_level;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0] flow_control_mode_select, next_flow_mode;
    logic [9:0] pin_mode, next_pin_mode;
    logic [4:0] pin_out_reg, next_pin_out_reg;
    logic [4:0] pin_dir, next_pin_dir;
    logic       int_flag, next_int_flag;
    logic       sleeping, next_sleeping;
    logic       clear_hit;

    function automatic mhpi_pin_mode_t mode_of(input logic [9:0] m, input int idx);
        mode_of = mhpi_pin_mode_t'(m[2*idx +: 2]);
    endfunction : mode_of

    assign clear_hit = reg_wr & (reg_addr == ADDR_INT_CLEAR)
                     & (reg_wdata[INT_CLEAR_HI:INT_CLEAR_LO] != 2'b00);

    always_comb begin
        next_flow_mode   = flow_control_mode_select;
        next_pin_mode    = pin_mode;
        next_pin_out_reg = pin_out_reg;
        next_pin_dir     = pin_dir;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_FLOW_MODE: next_flow_mode = {reg_wdata[FLOW_MODE_BIT], 7'h00};
                ADDR_PIN_MODE:  next_pin_mode  = reg_wdata[7] ? {reg_wdata[4:0], pin_mode[4:0]}
                    : {pin_mode[9:5], reg_wdata[4:0]};
                ADDR_PIN_OUT:   next_pin_out_reg = reg_wdata[4:0];
                ADDR_PIN_DIR:   next_pin_dir   = reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_int_flag = int_flag;
        if (clear_hit) begin
            next_int_flag = 1'b0;
        end
        // A new event in the clearing cycle wins.
        if (mode_of(pin_mode, 3) == MHPI_PIN_ALT && modem_state.connected && (|modem_events)) begin
            next_int_flag = 1'b1;
        end
        next_sleeping = modem_state.sleeping;
    end

    always_ff @(posedge clk) begin
        if (soft_rst) begin
            flow_control_mode_select <= RST_FLOW_MODE;
            pin_mode                 <= RST_PIN_MODE;
            pin_out_reg              <= RST_PIN_OUT;
            pin_dir                  <= RST_PIN_DIR;
            int_flag                 <= 1'b0;
            sleeping                 <= 1'b0;
        end else begin
            flow_control_mode_select <= next_flow_mode;
            pin_mode                 <= next_pin_mode;
            pin_out_reg              <= next_pin_out_reg;
            pin_dir                  <= next_pin_dir;
            int_flag                 <= next_int_flag;
            sleeping                 <= next_sleeping;
        end
    end

    // ****************************************************************
    // Clear-to-send
    // ****************************************************************
    logic cts_ok, next_cts_ok;
    always_comb begin
        next_cts_ok = cts_ok;
        if (!flow_control_mode_select[FLOW_MODE_BIT]) begin
            if (start_seen) begin
                next_cts_ok = 1'b0;
            end else if (level == '0 && !rx_byte_valid) begin
                next_cts_ok = 1'b1;
            end
        end else begin
            if (next_level >= HI_MARK) begin
                next_cts_ok = 1'b0;
            end else if (next_level <= LO_MARK) begin
                next_cts_ok = 1'b1;
            end
        end
        if (next_level == OW'(DEPTH)) begin
            next_cts_ok = 1'b0;
        end
    end

    // ****************************************************************
    // Pin outputs, escape and wake
    // ****************************************************************
    logic [4:0] next_pin_out, next_pin_oe;
    logic       esc_prev, next_esc, next_wake, rst_prev;

    always_comb begin
        next_pin_out = 5'h00;
        next_pin_oe  = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (mode_of(pin_mode, i) == MHPI_PIN_OUT) begin
                next_pin_out[i] = pin_out_reg[i];
                next_pin_oe[i]  = 1'b1;
            end
        end
        if (mode_of(pin_mode, 4) == MHPI_PIN_ALT) begin
            next_pin_out[4] = modem_state.ring_on;
            next_pin_oe[4]  = 1'b1;
        end
        if (mode_of(pin_mode, 3) == MHPI_PIN_ALT) begin
            next_pin_out[3] = int_flag;
            next_pin_oe[3]  = 1'b1;
        end
        if (mode_of(pin_mode, 1) == MHPI_PIN_ALT) begin
            next_pin_out[1] = ~modem_state.carrier_present;
            next_pin_oe[1]  = 1'b1;
        end
        if (mode_of(pin_mode, 0) == MHPI_PIN_ALT) begin
            next_pin_out[0] = modem_state.frame_end;
            next_pin_oe[0]  = 1'b1;
        end
        next_esc  = (mode_of(pin_mode, 2) == MHPI_PIN_ALT) & pin_s[2] & ~esc_prev
                  & modem_state.connected;
        next_wake = rst_n_s & ~rst_prev & modem_state.sleeping;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_prev <= 1'b1;
        end else begin
            rst_prev <= rst_n_s;
        end
        if (soft_rst) begin
            cts_ok            <= 1'b1;
            cts_n_pin         <= 1'b0;
            multi_pin_out     <= 5'h00;
            multi_pin_oe      <= 5'h00;
            esc_prev          <= 1'b0;
            escape_to_command <= 1'b0;
            wake_pulse        <= 1'b0;
            tx_fifo_valid     <= 1'b0;
            tx_fifo_data      <= 8'h00;
        end else begin
            cts_ok            <= next_cts_ok;
            cts_n_pin         <= ~next_cts_ok;
            multi_pin_out     <= next_pin_out;
            multi_pin_oe      <= next_pin_oe;
            esc_prev          <= pin_s[2];
            escape_to_command <= next_esc;
            wake_pulse        <= next_wake;
            tx_fifo_valid     <= next_level != '0;
            tx_fifo_data      <= mem[next_rptr];
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_FLOW_MODE: next_rdata = {flow_control_mode_select[FLOW_MODE_BIT], 7'h00};
                ADDR_INT_CLEAR: next_rdata = {int_flag, 7'h00};
                ADDR_PIN_MODE:  next_rdata = {3'h0, pin_mode[4:0]};
                ADDR_PIN_OUT:   next_rdata = {3'h0, pin_out_reg};
                ADDR_PIN_DIR:   next_rdata = {3'h0, pin_dir};
                ADDR_STATUS:    next_rdata = {cts_ok, sleeping, 2'h0, level[3:0]};
                ADDR_PIN_IN:    next_rdata = {3'h0, pin_s};
                ADDR_RX_DATA:   next_rdata = tx_fifo_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : mhpi_top

/* File: tb/mhpi_asserts.sv */
// Checker for the host pin interface ports.
`timescale 1ns/1ns
module mhpi_asserts (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       reset_n_pin,
    input wire logic       txd_pin,
    input wire logic       rxd_pin,
    input wire logic       cts_n_pin,
    input wire logic [4:0] multi_pin_oe,
    input wire logic       tx_fifo_valid,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic       escape_to_command,
    input wire logic       wake_pulse,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata
);
    logic mode, next_mode;
    always_comb begin
        next_mode = mode;
        if (reg_wr && reg_addr == 4'h0) next_mode = reg_wdata[7];
        if (sys_rst || !reset_n_pin) next_mode = 1'b0;
    end
    always_ff @(posedge clk) mode <= next_mode;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_mode_rd; $past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata[6:0] == 7'h00; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("flow mode low bits set");
    property p_idle_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data outside read slot");
    property p_start_cts; !mode && $fell(txd_pin) |-> ##[1:6] cts_n_pin; endproperty
    a_start_cts: assert property (p_start_cts) else $error("start bit kept cts");
    property p_level_cts; mode && !tx_fifo_valid |-> ##[0:3] !cts_n_pin; endproperty
    a_level_cts: assert property (p_level_cts) else $error("empty fifo negated cts");
    property p_pin_rst; !reset_n_pin [*4] |-> multi_pin_oe == 5'h00; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin driven in reset");
    property p_esc; escape_to_command |=> !escape_to_command; endproperty
    a_esc: assert property (p_esc) else $error("escape pulse too long");
    property p_wake; wake_pulse |=> !wake_pulse; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    property p_rx_start; rx_valid && rx_ready |-> ##[1:3] !rxd_pin; endproperty
    a_rx_start: assert property (p_rx_start) else $error("no start bit");
endmodule : mhpi_asserts
bind mhpi_top mhpi_asserts u_chk (.clk, .sys_rst, .reset_n_pin, .txd_pin, .rxd_pin, .cts_n_pin, .multi_pin_oe,
    .tx_fifo_valid, .rx_valid, .rx_ready, .escape_to_command, .wake_pulse, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);

/* File: tb/mhpi_host_model.sv */
// Host model that sends characters on the serial data line.
`timescale 1ns/1ns
module mhpi_host_model #(
    parameter int BITC = 8
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] data,
    input  wire logic       cts_n_pin,
    output logic            txd_pin,
    output logic            busy
);
    logic [9:0] frame;
    initial begin
        txd_pin = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                frame = {1'b1, data, 1'b0};
                while (cts_n_pin) @(posedge clk);
                for (int i = 0; i < 10; i++) begin
                    txd_pin <= frame[i];
                    repeat (BITC) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : mhpi_host_model

/* File: tb/testbench.sv */
// Self-checking bench of the host pin interface.
`timescale 1ns/1ns
module testbench;
    import mhpi_pkg::*;
    localparam int HI = 16 * 7 / 10;
    localparam int LO = (16 * 3 + 9) / 10;
    logic clk, sys_rst, reset_n_pin, txd_pin, rxd_pin, cts_n_pin, tx_fifo_pop, tx_fifo_valid, rx_valid, rx_ready;
    logic escape_to_command, wake_pulse, reg_wr, reg_rd, go, busy;
    logic [4:0] multi_pin_in, multi_pin_out, multi_pin_oe;
    logic [7:0] tx_fifo_data, rx_data, reg_wdata, reg_rdata, hdata, got;
    logic [3:0] reg_addr;
    mhpi_events_t modem_events;
    mhpi_modem_state_t modem_state;
    int err_count = 0, checks_done = 0;
    mhpi_top #(.DEPTH(16), .BIT_CYCLES(8)) dut (.clk, .sys_rst, .reset_n_pin, .txd_pin, .rxd_pin, .cts_n_pin,
        .multi_pin_in, .multi_pin_out, .multi_pin_oe, .modem_events, .modem_state, .tx_fifo_pop, .tx_fifo_valid,
        .tx_fifo_data, .rx_valid, .rx_data, .rx_ready, .escape_to_command, .wake_pulse, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    mhpi_host_model #(.BITC(8)) host (.clk, .go, .data(hdata), .cts_n_pin, .txd_pin, .busy);
    task automatic finish_test();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic await(ref logic s, input logic v);
        int n = 0;
        while (s !== v) begin
            @(posedge clk);
            n++;
            if (n > 3000) begin
                err_count++;
                $display("mismatch at %0t: wait expired", $time);
                finish_test();
            end
        end
        checks_done++;
    endtask : await
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(reg_rdata & m, e);
    endtask : rdc
    task automatic send(input logic [7:0] d);
        hdata <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        await(busy, 1'b0);
        repeat (4) @(posedge clk);
    endtask : send
    task automatic pop();
        tx_fifo_pop <= 1'b1;
        @(posedge clk);
        tx_fifo_pop <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pop
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {sys_rst, reset_n_pin, reg_rd, reg_wr, go, tx_fifo_pop, rx_valid} = 7'b1100000;
        {multi_pin_in, modem_events, modem_state, rx_data, hdata, reg_addr, reg_wdata} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(4'h0, 8'hff, 8'h00);
        wr(4'h0, 8'hff);
        rdc(4'h0, 8'hff, 8'h80);
        rdc(4'h8, 8'hff, 8'h00);
        wr(4'h0, 8'h00);
        send(8'ha5);
        check({7'h0, cts_n_pin}, 8'h01);
        check(tx_fifo_data, 8'ha5);
        pop();
        check({7'h0, cts_n_pin}, 8'h00);
        wr(4'h0, 8'h80);
        for (int i = 1; i <= HI; i++) begin
            send(8'(i));
            check({7'h0, cts_n_pin}, {7'h0, i >= HI});
        end
        for (int i = HI - 1; i >= 0; i--) begin
            check(tx_fifo_data, 8'(HI - i));
            pop();
            check({7'h0, cts_n_pin}, {7'h0, i > LO});
        end
        rx_data <= 8'h3c;
        rx_valid <= 1'b1;
        @(posedge clk);
        await(rx_ready, 1'b1);
        rx_valid <= 1'b0;
        await(rxd_pin, 1'b0);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (8) @(posedge clk);
            if (i < 8) got[i] = rxd_pin;
        end
        check(got, 8'h3c);
        check({7'h0, rxd_pin}, 8'h01);
        modem_state <= 5'b01010;
        wr(4'h2, 8'h08);
        @(posedge clk);
        wr(4'h2, 8'h85);
        repeat (3) @(posedge clk);
        check({6'h0, multi_pin_oe[1], multi_pin_out[1]}, 8'h02);
        multi_pin_in[2] <= 1'b1;
        await(escape_to_command, 1'b1);
        for (int i = 0; i < 5; i++) begin
            modem_events <= 5'(5'h01 << i);
            @(posedge clk);
            modem_events <= 5'h00;
            repeat (4) @(posedge clk);
            rdc(4'h1, 8'h80, 8'h80);
            wr(4'h1, 8'hc0);
            rdc(4'h1, 8'h80, 8'h00);
        end
        modem_state <= 5'h01;
        reset_n_pin <= 1'b0;
        repeat (5) @(posedge clk);
        check({3'h0, multi_pin_oe}, 8'h00);
        reset_n_pin <= 1'b1;
        await(wake_pulse, 1'b1);
        rdc(4'h0, 8'hff, 8'h00);
        finish_test();
    end
endmodule : testbench
